// [hw/ddr2_pin_pkg.sv]
// constants and types for the ddr2 pin interface logic
// assumes one link clock from the controller and one core clock on the user side
package ddr2_pin_pkg;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS
  } cmd_type;

  typedef enum logic [1:0] {
    PW_ACTIVE, PW_PRE_PD, PW_ACT_PD, PW_SREF
  } pwr_type;

  // organisation strap codes
  localparam logic [1:0] ORG_X4  = 2'h0;
  localparam logic [1:0] ORG_X8  = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;

  // bank address codes during a mode register set
  localparam logic [1:0] SEL_MR   = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;

  // field positions in the mode registers and the auto-precharge address bit
  localparam int MR_BL_LSB    = 0;
  localparam int MR_CL_LSB    = 4;
  localparam int EMR_RTT0_BIT = 2;
  localparam int EMR_AL_LSB   = 3;
  localparam int EMR_RTT1_BIT = 6;
  localparam int EMR_DQSN_BIT = 10;
  localparam int EMR_RDQS_BIT = 11;
  localparam int ADDR_AP_BIT  = 10;

  localparam logic [2:0] MR_BL8     = 3'h3;
  localparam logic [2:0] PAIRS_BL4  = 3'h2;
  localparam logic [2:0] PAIRS_BL8  = 3'h4;

  localparam logic [13:0] MR_RESET   = 14'h0000;
  localparam logic [13:0] EMR1_RESET = 14'h0000;
  localparam logic [31:0] FILL_RESET = 32'h0000_0000;

endpackage : ddr2_pin_pkg

// [hw/ddr2_sdram_pin_interface.sv]
// ddr2 device pin logic: command capture, mode registers, power states, data lanes
// assumes ck is the controller's clock with pins timed to it; mclk is the core clock
// Operation
// - capture address and control pins on the rising ck crossing
// - launch read data on both ck half-periods, one beat each
// - cke high keeps clocks, inputs and drivers alive; low shuts them down
// - cke drop: idle banks give precharge power-down or self refresh, else active power-down
// - cke synchronous for power-down and self-refresh entry; asynchronous self-refresh exit
// - inputs except clock and cke off in power-down; all but cke in self refresh
// - chip select high at the edge masks every command
// - command decoded from ras, cas, we and chip select at the edge
// - odt registered high turns on termination on data, strobe and mask lanes
// - odt ignored when first extended mode register disables termination
// - write beats with mask high discarded; mask sampled on both edges
// - x8 mask pin becomes read strobe when extended bit a11 is set
// - bank address picks mode or extended mode register during mode set
// - row address on activate; column and auto-precharge on read and write
// - precharge: a10 low one bank, a10 high all banks
// - mode register set loads the address opcode into the chosen register
// - read strobe edge aligned with data; write strobe centred by controller
// - x16 lower strobe times data 0 to 7, upper strobe 8 to 15
// - extended bit a10 zero: differential strobes; one: complements disabled
module ddr2_sdram_pin_interface (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 ck,
  input  wire logic                 cke,
  input  wire logic                 csN,
  input  wire logic                 rasN,
  input  wire logic                 casN,
  input  wire logic                 weN,
  input  wire logic [2:0]           ba,
  input  wire logic [13:0]          addr,
  input  wire logic                 odt,
  input  wire logic [15:0]          dqIn,
  input  wire logic [1:0]           dmIn,
  input  wire logic [1:0]           orgSel,
  input  wire logic [31:0]          fillData,
  input  wire logic                 fillLoad,
  output logic [15:0]               dqRise,
  output logic [15:0]               dqFall,
  output logic [1:0]                dqOe,
  output logic [1:0]                dqsOe,
  output logic [1:0]                dqsNOe,
  output logic                      rdqsOe,
  output logic                      rdqsNOe,
  output logic                      termOn,
  output logic                      cmdValid,
  output ddr2_pin_pkg::cmd_type     cmdCode,
  output logic [1:0]                cmdBank,
  output logic [13:0]               cmdAddr,
  output logic                      wrValid,
  output logic [31:0]               wrData,
  output logic                      powerDown,
  output logic                      selfRefresh
);

  typedef struct packed {
    logic                  ckePrev;
    ddr2_pin_pkg::pwr_type pwr;
    logic [1:0]            orgMeta;
    logic [1:0]            org;
    logic [13:0]           mr;
    logic [13:0]           emr1;
    logic [3:0]            bankOpen;
    logic [3:0][13:0]      row;
    logic [3:0]            rdLat;
    logic [2:0]            rdPairs;
    logic [3:0]            wrLat;
    logic [2:0]            wrPairs;
    logic [15:0]           riseHold;
    logic [1:0]            riseMask;
    logic [31:0]           wrWord;
    logic                  wrTgl;
    ddr2_pin_pkg::cmd_type evtCmd;
    logic [1:0]            evtBank;
    logic [13:0]           evtAddr;
    logic                  evtTgl;
    logic [2:0]            fillSync;
    logic [31:0]           fill;
    logic                  srMeta;
    logic                  srSeen;
    logic                  inPd;
    logic [15:0]           dqRise;
    logic [15:0]           dqFall;
    logic [1:0]            dqOe;
    logic [1:0]            dqsOe;
    logic [1:0]            dqsNOe;
    logic                  rdqsOe;
    logic                  rdqsNOe;
    logic                  termOn;
  } link_type;

  typedef struct packed {
    logic [31:0]           fillWord;
    logic                  fillTgl;
    logic [2:0]            evtSync;
    logic [2:0]            wrSync;
    logic                  pdMeta;
    logic                  srMeta;
    logic                  powerDown;
    logic                  selfRefresh;
    logic                  cmdValid;
    ddr2_pin_pkg::cmd_type cmdCode;
    logic [1:0]            cmdBank;
    logic [13:0]           cmdAddr;
    logic                  wrValid;
    logic [31:0]           wrData;
  } core_type;

  link_type   link_reg, link_next;
  core_type   core_reg, core_next;
  logic [1:0] linkRstSync;
  logic       linkRstN;
  logic       srefLatch;
  logic       srefEnter;
  logic [15:0] fallDq;
  logic [1:0]  fallDm;

  // reset reaches the link domain through two flops
  always_ff @(posedge ck) begin
    linkRstSync <= {linkRstSync[0], nrst};
  end
  assign linkRstN = linkRstSync[1];

  // self-refresh exit must not wait for ck, which may be stopped
  always_ff @(posedge ck or posedge cke) begin
    if (cke) begin
      srefLatch <= 1'b0;
    end else if (!linkRstN) begin
      srefLatch <= 1'b0;
    end else if (srefEnter) begin
      srefLatch <= 1'b1;
    end
  end

  // falling-edge beat of write data and mask
  always_ff @(negedge ck) begin
    fallDq <= dqIn;
    fallDm <= dmIn;
  end

  function automatic ddr2_pin_pkg::cmd_type decode(input logic cs, input logic r,
                                                   input logic c, input logic w);
    ddr2_pin_pkg::cmd_type res;
    res = ddr2_pin_pkg::CMD_NOP;
    if (!cs) begin
      case ({r, c, w})
        3'h3:    res = ddr2_pin_pkg::CMD_ACT;
        3'h5:    res = ddr2_pin_pkg::CMD_READ;
        3'h4:    res = ddr2_pin_pkg::CMD_WRITE;
        3'h2:    res = ddr2_pin_pkg::CMD_PRE;
        3'h1:    res = ddr2_pin_pkg::CMD_REF;
        3'h0:    res = ddr2_pin_pkg::CMD_MRS;
        default: res = ddr2_pin_pkg::CMD_NOP;
      endcase
    end
    return res;
  endfunction

  always_comb begin
    ddr2_pin_pkg::cmd_type cmd;
    logic                  live;
    logic                  allIdle;
    logic [3:0]            rl;
    logic [2:0]            pairs;
    logic                  maskOn;
    logic                  reading;
    logic                  x16;
    logic [31:0]           beat;
    logic [3:0]            mask;
    cmd       = decode(csN, rasN, casN, weN);
    live      = 1'b0;
    allIdle   = 1'b0;
    rl        = 4'h0;
    pairs     = 3'h0;
    maskOn    = 1'b0;
    reading   = 1'b0;
    x16       = 1'b0;
    beat      = 32'h0;
    mask      = 4'h0;
    srefEnter = 1'b0;
    link_next = link_reg;

    link_next.ckePrev = cke;
    link_next.orgMeta = orgSel;
    link_next.org     = link_reg.orgMeta;
    link_next.srMeta  = srefLatch;
    link_next.srSeen  = link_reg.srMeta;
    link_next.fillSync = {link_reg.fillSync[1:0], core_reg.fillTgl};
    if (link_reg.fillSync[2] != link_reg.fillSync[1]) begin
      link_next.fill = core_reg.fillWord;
    end

    allIdle = (link_reg.bankOpen == 4'h0);
    live    = (link_reg.pwr == ddr2_pin_pkg::PW_ACTIVE) && link_reg.ckePrev && cke;
    rl      = 4'(link_reg.mr[ddr2_pin_pkg::MR_CL_LSB +: 3]) +
              4'(link_reg.emr1[ddr2_pin_pkg::EMR_AL_LSB +: 3]);
    pairs   = (link_reg.mr[ddr2_pin_pkg::MR_BL_LSB +: 3] == ddr2_pin_pkg::MR_BL8) ?
              ddr2_pin_pkg::PAIRS_BL8 : ddr2_pin_pkg::PAIRS_BL4;
    x16     = (link_reg.org == ddr2_pin_pkg::ORG_X16);
    maskOn  = !((link_reg.org == ddr2_pin_pkg::ORG_X8) &&
                link_reg.emr1[ddr2_pin_pkg::EMR_RDQS_BIT]);

    // power state
    case (link_reg.pwr)
      ddr2_pin_pkg::PW_ACTIVE: begin
        if (link_reg.ckePrev && !cke) begin
          if (allIdle && cmd == ddr2_pin_pkg::CMD_REF) begin
            link_next.pwr = ddr2_pin_pkg::PW_SREF;
            srefEnter     = 1'b1;
          end else if (allIdle) begin
            link_next.pwr = ddr2_pin_pkg::PW_PRE_PD;
          end else begin
            link_next.pwr = ddr2_pin_pkg::PW_ACT_PD;
          end
        end
      end
      ddr2_pin_pkg::PW_PRE_PD, ddr2_pin_pkg::PW_ACT_PD: begin
        if (cke) begin
          link_next.pwr = ddr2_pin_pkg::PW_ACTIVE;
        end
      end
      ddr2_pin_pkg::PW_SREF: begin
        if (cke && !link_reg.srSeen) begin
          link_next.pwr = ddr2_pin_pkg::PW_ACTIVE;
        end
      end
      default: link_next.pwr = ddr2_pin_pkg::PW_ACTIVE;
    endcase
    link_next.inPd = (link_next.pwr == ddr2_pin_pkg::PW_PRE_PD) ||
                     (link_next.pwr == ddr2_pin_pkg::PW_ACT_PD);

    // commands
    if (live && cmd != ddr2_pin_pkg::CMD_NOP) begin
      link_next.evtCmd  = cmd;
      link_next.evtBank = ba[1:0];
      link_next.evtAddr = addr;
      link_next.evtTgl  = !link_reg.evtTgl;
      case (cmd)
        ddr2_pin_pkg::CMD_ACT: begin
          link_next.bankOpen[ba[1:0]] = 1'b1;
          link_next.row[ba[1:0]]      = addr;
        end
        ddr2_pin_pkg::CMD_READ, ddr2_pin_pkg::CMD_WRITE: begin
          // auto-precharge closes the bank at once; no row timing is modelled
          if (addr[ddr2_pin_pkg::ADDR_AP_BIT]) begin
            link_next.bankOpen[ba[1:0]] = 1'b0;
          end
          if (cmd == ddr2_pin_pkg::CMD_READ) begin
            link_next.rdLat = rl;
          end else begin
            link_next.wrLat = rl - 4'h1;
          end
        end
        ddr2_pin_pkg::CMD_PRE: begin
          if (addr[ddr2_pin_pkg::ADDR_AP_BIT]) begin
            link_next.bankOpen = 4'h0;
          end else begin
            link_next.bankOpen[ba[1:0]] = 1'b0;
          end
        end
        ddr2_pin_pkg::CMD_MRS: begin
          if (ba[1:0] == ddr2_pin_pkg::SEL_MR) begin
            link_next.mr = addr;
          end else if (ba[1:0] == ddr2_pin_pkg::SEL_EMR1) begin
            link_next.emr1 = addr;
          end
        end
        default: begin
        end
      endcase
    end

    // read burst: pairs start at edge rl after the command
    if (link_reg.rdLat != 4'h0) begin
      link_next.rdLat = link_reg.rdLat - 4'h1;
      if (link_reg.rdLat == 4'h1) begin
        link_next.rdPairs = pairs;
      end
    end else if (link_reg.rdPairs != 3'h0) begin
      link_next.rdPairs = link_reg.rdPairs - 3'h1;
    end
    reading = (link_next.rdPairs != 3'h0) && (link_next.pwr == ddr2_pin_pkg::PW_ACTIVE);
    link_next.dqRise  = link_reg.fill[15:0];
    link_next.dqFall  = link_reg.fill[31:16];
    link_next.dqOe    = {reading && x16, reading};
    link_next.dqsOe   = {reading && x16, reading};
    link_next.dqsNOe  = link_next.dqsOe &
                        {2{!link_reg.emr1[ddr2_pin_pkg::EMR_DQSN_BIT]}};
    link_next.rdqsOe  = reading && !maskOn;
    link_next.rdqsNOe = reading && !maskOn &&
                        !link_reg.emr1[ddr2_pin_pkg::EMR_DQSN_BIT];

    // write burst: rise beat held, merged with the following fall beat
    if (link_reg.wrPairs != 3'h0) begin
      beat = {fallDq, link_reg.riseHold};
      mask = {fallDm, link_reg.riseMask} & {4{maskOn}};
      for (int b = 0; b < 4; b++) begin
        if (!mask[b]) begin
          link_next.wrWord[b*8 +: 8] = beat[b*8 +: 8];
        end
      end
      // one toggle per burst: pairs closer than an mclk would cancel out
      if (link_reg.wrPairs == 3'h1) begin
        link_next.wrTgl = !link_reg.wrTgl;
      end
      link_next.wrPairs = link_reg.wrPairs - 3'h1;
    end
    if (link_reg.wrLat != 4'h0) begin
      link_next.wrLat = link_reg.wrLat - 4'h1;
      if (link_reg.wrLat == 4'h1) begin
        link_next.wrPairs = pairs;
      end
    end
    link_next.riseHold = dqIn;
    link_next.riseMask = dmIn;

    // termination: odt sampled only in the active state; termOn held in power-down, cleared in self refresh
    if (live) begin
      link_next.termOn = odt && (link_reg.emr1[ddr2_pin_pkg::EMR_RTT0_BIT] ||
                                 link_reg.emr1[ddr2_pin_pkg::EMR_RTT1_BIT]);
    end else if (link_reg.pwr == ddr2_pin_pkg::PW_SREF) begin
      link_next.termOn = 1'b0;
    end

    if (!linkRstN) begin
      link_next          = '0;
      link_next.ckePrev  = cke;
      link_next.pwr      = ddr2_pin_pkg::PW_ACTIVE;
      link_next.mr       = ddr2_pin_pkg::MR_RESET;
      link_next.emr1     = ddr2_pin_pkg::EMR1_RESET;
      link_next.fill     = ddr2_pin_pkg::FILL_RESET;
      link_next.evtCmd   = ddr2_pin_pkg::CMD_NOP;
      link_next.fillSync = {3{core_reg.fillTgl}};
    end
  end

  always_ff @(posedge ck) begin
    link_reg <= link_next;
  end

  // core side: toggles detected after two flops, held words then stable
  always_comb begin
    core_next = core_reg;
    core_next.evtSync  = {core_reg.evtSync[1:0], link_reg.evtTgl};
    core_next.wrSync   = {core_reg.wrSync[1:0], link_reg.wrTgl};
    core_next.pdMeta   = link_reg.inPd;
    core_next.powerDown = core_reg.pdMeta;
    core_next.srMeta   = link_reg.srSeen;
    core_next.selfRefresh = core_reg.srMeta;
    core_next.cmdValid = core_reg.evtSync[2] != core_reg.evtSync[1];
    core_next.wrValid  = core_reg.wrSync[2] != core_reg.wrSync[1];
    if (core_next.cmdValid) begin
      core_next.cmdCode = link_reg.evtCmd;
      core_next.cmdBank = link_reg.evtBank;
      core_next.cmdAddr = link_reg.evtAddr;
    end
    if (core_next.wrValid) begin
      core_next.wrData = link_reg.wrWord;
    end
    if (fillLoad) begin
      core_next.fillWord = fillData;
      core_next.fillTgl  = !core_reg.fillTgl;
    end
    if (!nrst) begin
      core_next          = '0;
      core_next.fillWord = ddr2_pin_pkg::FILL_RESET;
      core_next.cmdCode  = ddr2_pin_pkg::CMD_NOP;
      core_next.evtSync  = {3{link_reg.evtTgl}};
      core_next.wrSync   = {3{link_reg.wrTgl}};
    end
  end

  always_ff @(posedge mclk) begin
    core_reg <= core_next;
  end

  assign dqRise      = link_reg.dqRise;
  assign dqFall      = link_reg.dqFall;
  assign dqOe        = link_reg.dqOe;
  assign dqsOe       = link_reg.dqsOe;
  assign dqsNOe      = link_reg.dqsNOe;
  assign rdqsOe      = link_reg.rdqsOe;
  assign rdqsNOe     = link_reg.rdqsNOe;
  assign termOn      = link_reg.termOn;
  assign cmdValid    = core_reg.cmdValid;
  assign cmdCode     = core_reg.cmdCode;
  assign cmdBank     = core_reg.cmdBank;
  assign cmdAddr     = core_reg.cmdAddr;
  assign wrValid     = core_reg.wrValid;
  assign wrData      = core_reg.wrData;
  assign powerDown   = core_reg.powerDown;
  assign selfRefresh = core_reg.selfRefresh;

endmodule // ddr2_sdram_pin_interface

// [verif/ddr2_pin_checker_sva.sv]
// concurrent checks on the ddr2 pin logic ports, core and link clock domains
// assumes binding onto the top module; nrst qualifies both domains
module ddr2_pin_checker (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic                  ck,
  input wire logic [1:0]            orgSel,
  input wire logic [1:0]            dqOe,
  input wire logic [1:0]            dqsOe,
  input wire logic [1:0]            dqsNOe,
  input wire logic                  rdqsOe,
  input wire logic                  rdqsNOe,
  input wire logic                  termOn,
  input wire logic                  cmdValid,
  input wire ddr2_pin_pkg::cmd_type cmdCode,
  input wire logic                  wrValid,
  input wire logic                  powerDown,
  input wire logic                  selfRefresh
);
  timeunit 1ns;
  timeprecision 100ps;

  a_cmd_one_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    cmdValid |=> !cmdValid) else $error("cmdValid wider than one cycle");
  a_sref_mutes_cmd: assert property (@(posedge mclk) disable iff (!nrst)
    selfRefresh [*8] |-> !cmdValid) else $error("command seen in self refresh");
  a_pd_no_drive: assert property (@(posedge mclk) disable iff (!nrst)
    powerDown |-> dqOe == 2'h0) else $error("data driven in power-down");
  a_sref_no_term: assert property (@(posedge mclk) disable iff (!nrst)
    selfRefresh [*4] ##1 selfRefresh |-> !$past(termOn))
    else $error("termination on in self refresh");
  a_dqs_with_dq: assert property (@(posedge ck) disable iff (!nrst)
    dqOe[0] |-> dqsOe[0]) else $error("read data without strobe");
  a_upper_x16: assert property (@(posedge ck) disable iff (!nrst)
    dqOe[1] |-> orgSel == ddr2_pin_pkg::ORG_X16 && dqsOe[1])
    else $error("upper lane driven off x16 or without its strobe");
  a_dqsn_pairs: assert property (@(posedge ck) disable iff (!nrst)
    |dqsNOe |-> dqsNOe == dqsOe) else $error("complement strobe mismatch");
  a_rdqs_x8: assert property (@(posedge ck) disable iff (!nrst)
    rdqsOe |-> orgSel == ddr2_pin_pkg::ORG_X8 && dqsOe[0])
    else $error("read strobe on mask pin off x8");
  a_rdqs_n: assert property (@(posedge ck) disable iff (!nrst)
    rdqsNOe |-> rdqsOe) else $error("rdqs complement alone");
  a_burst_pairs: assert property (@(posedge ck) disable iff (!nrst)
    $rose(dqOe[0]) |-> dqOe[0] ##1 dqOe[0]) else $error("read burst too short");

  c_mrs: cover property (@(posedge mclk) cmdValid && cmdCode == ddr2_pin_pkg::CMD_MRS);
  c_sref: cover property (@(posedge mclk) $rose(selfRefresh));
  c_rdqs: cover property (@(posedge ck) rdqsOe);
  c_wr: cover property (@(posedge mclk) wrValid);
endmodule // ddr2_pin_checker

// [verif/ddr2_ctrl_model.sv]
// behavioural memory controller driving command, address and write data pins
// assumes ck runs free; pins change at ck falling edge, write data also at rising
module ddr2_ctrl_model (
  input  wire logic  ck,
  output logic       cke,
  output logic       csN,
  output logic       rasN,
  output logic       casN,
  output logic       weN,
  output logic [2:0]  ba,
  output logic [13:0] addr,
  output logic       odt,
  output logic [15:0] dqIn,
  output logic [1:0]  dmIn
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {cke, csN, rasN, casN, weN} = 5'h1f;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b0;
    dqIn = 16'h0000;
    dmIn = 2'h0;
  end

  function automatic logic [2:0] enc(input ddr2_pin_pkg::cmd_type c);
    case (c)
      ddr2_pin_pkg::CMD_ACT:   return 3'h3;
      ddr2_pin_pkg::CMD_READ:  return 3'h5;
      ddr2_pin_pkg::CMD_WRITE: return 3'h4;
      ddr2_pin_pkg::CMD_PRE:   return 3'h2;
      ddr2_pin_pkg::CMD_REF:   return 3'h1;
      ddr2_pin_pkg::CMD_MRS:   return 3'h0;
      default:                 return 3'h7;
    endcase
  endfunction

  // cke only moves with a command slot, never inside a burst
  task automatic cmd(input ddr2_pin_pkg::cmd_type c, input logic cs, input logic k,
                     input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    cke <= k;
    {csN, rasN, casN, weN} <= {cs, enc(c)};
    ba <= b;
    addr <= a;
    @(negedge ck);
    {csN, rasN, casN, weN} <= 4'hf;
    addr <= ~a;
  endtask

  // two beat pairs; each beat set half a ck ahead of the edge sampling it
  task automatic wr(input logic [63:0] d, input logic [7:0] m);
    for (int i = 0; i < 4; i++) begin
      if (i[0])
        @(posedge ck);
      else
        @(negedge ck);
      dqIn <= d[i*16 +: 16];
      dmIn <= m[i*2 +: 2];
    end
    @(negedge ck);
    dqIn <= ~d[63:48];
    dmIn <= ~m[7:6];
  endtask
endmodule // ddr2_ctrl_model

// [verif/ddr2_sdram_pin_interface_test.sv]
// self-checking bench for the ddr2 pin logic with a behavioural controller
// assumes mclk 8 ns and a free running 6 ns ck of unrelated phase
module ddr2_sdram_pin_interface_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk, nrst, ck, cke, csN, rasN, casN, weN, odt, fillLoad;
  logic rdqsOe, rdqsNOe, termOn, cmdValid, wrValid, powerDown, selfRefresh;
  logic [2:0]  ba;
  logic [13:0] addr, cmdAddr;
  logic [15:0] dqIn, dqRise, dqFall;
  logic [1:0]  dmIn, orgSel, dqOe, dqsOe, dqsNOe, cmdBank;
  logic [31:0] fillData, wrData, fw;
  logic [63:0] wd;
  logic [7:0]  wm;
  ddr2_pin_pkg::cmd_type cmdCode;
  ddr2_pin_pkg::cmd_type kinds [4] = '{ddr2_pin_pkg::CMD_ACT, ddr2_pin_pkg::CMD_READ,
                                       ddr2_pin_pkg::CMD_WRITE, ddr2_pin_pkg::CMD_PRE};
  int seed = 67552;
  int nMismatch = 0;
  int nTests = 0;

  ddr2_sdram_pin_interface i_dut (.mclk, .nrst, .ck, .cke, .csN, .rasN, .casN, .weN,
    .ba, .addr, .odt, .dqIn, .dmIn, .orgSel, .fillData, .fillLoad, .dqRise, .dqFall,
    .dqOe, .dqsOe, .dqsNOe, .rdqsOe, .rdqsNOe, .termOn, .cmdValid, .cmdCode, .cmdBank,
    .cmdAddr, .wrValid, .wrData, .powerDown, .selfRefresh);
  ddr2_ctrl_model i_ctrl (.ck, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .odt,
    .dqIn, .dmIn);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    ck = 1'b0;
    #1.3;
    forever #3 ck = ~ck;
  end

  task automatic conclude;
    if (nMismatch == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] m);
    logic [31:0] r;
    for (int i = 0; i < 4; i++)
      r[i*8 +: 8] = m[i] ? o[i*8 +: 8] : n[i*8 +: 8];
    return r;
  endfunction

  task automatic go(input ddr2_pin_pkg::cmd_type c, input logic [2:0] b,
                    input logic [13:0] a);
    logic got = 1'b0;
    i_ctrl.cmd(c, 1'b0, 1'b1, b, a);
    for (int i = 0; i < 12 && got !== 1'b1; i++) begin
      @(negedge mclk);
      got = cmdValid;
    end
    check("cmdValid", got, 1);
    check("cmdCode", cmdCode, c);
    check("cmdBank", cmdBank, b[1:0]);
    check("cmdAddr", cmdAddr, a);
  endtask

  task automatic quiet(input string n);
    logic seen = 1'b0;
    repeat (12) begin
      @(negedge mclk);
      seen |= cmdValid;
    end
    check(n, seen, 0);
  endtask

  // read of one bl4 burst at rl 3; enables set at edges 3 and 4 after the command
  task automatic rd(input logic [1:0] oe, input logic [1:0] dn, input logic r);
    logic on;
    i_ctrl.cmd(ddr2_pin_pkg::CMD_READ, 1'b0, 1'b1, 3'h0, 14'h0000);
    for (int i = 2; i < 7; i++) begin
      @(negedge ck);
      on = (i == 4 || i == 5);
      check("dqOe", dqOe, on ? oe : 2'h0);
      check("dqsOe", dqsOe, on ? oe : 2'h0);
      check("dqsNOe", dqsNOe, on ? dn : 2'h0);
      check("rdqsOe", rdqsOe, on && r);
      if (on) begin
        check("dqRise", dqRise, fw[15:0]);
        check("dqFall", dqFall, fw[31:16]);
      end
    end
  endtask

  initial begin
    orgSel = ddr2_pin_pkg::ORG_X8;
    fillData = 32'h0000_0000;
    fillLoad = 1'b0;
    nrst = 1'b0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    repeat (8) @(negedge ck);
    go(ddr2_pin_pkg::CMD_MRS, 3'h0, 14'h0032);
    go(ddr2_pin_pkg::CMD_MRS, 3'h1, 14'h0804);
    @(negedge mclk);
    fw = $random(seed);
    fillData = fw;
    fillLoad = 1'b1;
    @(negedge mclk);
    fillLoad = 1'b0;
    go(ddr2_pin_pkg::CMD_ACT, 3'h0, 14'h0123);
    rd(2'h1, 2'h1, 1'b1);
    orgSel = ddr2_pin_pkg::ORG_X16;
    go(ddr2_pin_pkg::CMD_MRS, 3'h1, 14'h0404);
    rd(2'h3, 2'h0, 1'b0);
    wd = {$random(seed), $random(seed)};
    wm = {4'($random(seed)), 4'h0};
    i_ctrl.cmd(ddr2_pin_pkg::CMD_WRITE, 1'b0, 1'b1, 3'h0, 14'h0010);
    i_ctrl.wr(wd, wm);
    repeat (10) @(negedge mclk);
    check("wrData", wrData, merge(wd[31:0], wd[63:32], wm[7:4]));
    @(negedge ck) i_ctrl.odt <= 1'b1;
    repeat (8) @(negedge ck);
    check("termOn", termOn, 1);
    go(ddr2_pin_pkg::CMD_MRS, 3'h1, 14'h0400);
    repeat (8) @(negedge ck);
    check("termOn", termOn, 0);
    go(ddr2_pin_pkg::CMD_MRS, 3'h1, 14'h0404);
    for (int k = 0; k < 8; k++) begin
      go(kinds[k % 4], 3'($random(seed)), 14'($random(seed)));
      repeat (4) @(negedge ck);
    end
    i_ctrl.cmd(ddr2_pin_pkg::CMD_ACT, 1'b1, 1'b1, 3'h1, 14'h0fff);
    quiet("csHigh");
    go(ddr2_pin_pkg::CMD_PRE, 3'h0, 14'h0400);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_NOP, 1'b1, 1'b0, 3'h0, 14'h0000);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_ACT, 1'b0, 1'b0, 3'h1, 14'h0001);
    quiet("pdCmd");
    check("powerDown", powerDown, 1);
    check("selfRefresh", selfRefresh, 0);
    check("termOn", termOn, 1);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_NOP, 1'b1, 1'b1, 3'h0, 14'h0000);
    repeat (8) @(negedge mclk);
    check("powerDown", powerDown, 0);
    go(ddr2_pin_pkg::CMD_ACT, 3'h2, 14'h0055);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_NOP, 1'b1, 1'b0, 3'h0, 14'h0000);
    repeat (8) @(negedge mclk);
    check("powerDown", powerDown, 1);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_NOP, 1'b1, 1'b1, 3'h0, 14'h0000);
    repeat (8) @(negedge mclk);
    go(ddr2_pin_pkg::CMD_PRE, 3'h0, 14'h0400);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_REF, 1'b0, 1'b0, 3'h0, 14'h0000);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_ACT, 1'b0, 1'b0, 3'h1, 14'h0002);
    quiet("srefCmd");
    check("selfRefresh", selfRefresh, 1);
    check("termOn", termOn, 0);
    i_ctrl.cmd(ddr2_pin_pkg::CMD_NOP, 1'b1, 1'b1, 3'h0, 14'h0000);
    repeat (8) @(negedge ck);
    go(ddr2_pin_pkg::CMD_ACT, 3'h3, 14'h1abc);
    check("selfRefresh", selfRefresh, 0);
    conclude();
  end

  // whole sequence needs well under 10 us; ten times that means a hang
  initial begin
    #100000;
    nMismatch++;
    conclude();
  end
endmodule // ddr2_sdram_pin_interface_test

bind ddr2_sdram_pin_interface ddr2_pin_checker i_chk (.mclk, .nrst, .ck, .orgSel, .dqOe,
  .dqsOe, .dqsNOe, .rdqsOe, .rdqsNOe, .termOn, .cmdValid, .cmdCode, .wrValid, .powerDown,
  .selfRefresh);
